// File: core/ffch_hist.sv
// Purpose: Eight-entry alarm history store
// Assumes: One push or clear per cycle; clear wins
// Notes: Newest entry at index 0
`timescale 1ns/100ps
module ffch_hist
  import ffch_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic [7:0] code,
  input wire logic clear,
  input wire logic [2:0] rd_idx,
  output logic [7:0] rd_data
);
  logic [7:0] mem [HIST_DEPTH];

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < HIST_DEPTH; i++)
        mem[i] <= 8'h00;
    end
    else if (clear)
    begin
      for (int i = 0; i < HIST_DEPTH; i++)
        mem[i] <= 8'h00; // [R13]
    end
    else if (push)
    begin
      mem[0] <= code;
      for (int i = 1; i < HIST_DEPTH; i++)
        mem[i] <= mem[i-1];
    end
  end

  assign rd_data = mem[rd_idx];
endmodule

// File: core/ffch_pkg.sv
// Purpose: Shared constants for the fieldbus frequency command handler
// Assumes: 40 MHz mclk, registers reached over a plain strobe port
// Notes: All offsets are word indices on the register port
package ffch_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  // Link refresh window per station
  localparam int unsigned REFRESH_MIN_US10 = 11;
  localparam int unsigned REFRESH_MAX_MS = 141;
  localparam int unsigned REFRESH_MIN_CYC = (CLK_HZ / 10000) * REFRESH_MIN_US10;
  localparam int unsigned REFRESH_MAX_CYC = (CLK_HZ / 1000) * REFRESH_MAX_MS;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_FREQ = 4'h4;
  localparam logic [3:0] ADDR_NV_FREQ = 4'h5;
  localparam logic [3:0] ADDR_HIST_BASE = 4'h8;

  localparam int unsigned CTRL_SIGN_BIT = 0;
  localparam int unsigned CTRL_OCC_LSB = 8;
  localparam int unsigned CTRL_MODE_LSB = 16;

  localparam logic [7:0] OCC_LEGACY = 8'h00;
  localparam logic [7:0] OCC_SINGLE = 8'h01;
  localparam logic [7:0] OCC_DOUBLE = 8'h0C;
  localparam logic [7:0] OCC_QUAD = 8'h0E;
  localparam logic [7:0] OCC_OCT = 8'h12;

  localparam logic [3:0] MODE_COMB_A = 4'h1;
  localparam logic [3:0] MODE_COMB_B = 4'h3;

  localparam logic [7:0] SET_FREQ_RAM_CODE = 8'hED;
  localparam logic [7:0] SET_FREQ_NV_CODE = 8'hEE;
  localparam logic [7:0] REPLY_OK = 8'h00;
  localparam logic [7:0] REPLY_WRITE_MODE_ERR = 8'h01;
  localparam logic [7:0] REPLY_BAD_CODE = 8'h02;
  localparam logic [7:0] HIST_CLEAR_CODE = 8'hF4;

  localparam logic [15:0] FREQ_RESET = 16'h0000;
  localparam logic [7:0] CTRL_OCC_RESET = 8'h00;
  localparam int unsigned HIST_DEPTH = 8;

  // Interrupt status bits
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_ERR = 1;
  localparam int unsigned IRQ_RESET = 2;
  localparam int unsigned IRQ_W = 3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_DONE = 4'b0100,
    ST_WAIT = 4'b1000
  } ffch_state_t;

  typedef enum logic [1:0] {
    REQ_NONE = 2'h0,
    REQ_RAM = 2'h1,
    REQ_NV = 2'h2,
    REQ_INSTR = 2'h3
  } ffch_req_t;

  // Picks the request to serve; RAM write first, then NV, then instruction
  function automatic ffch_req_t ffch_pick(input logic ram, input logic nv, input logic ins);
    if (ram)
      return REQ_RAM;
    else if (nv)
      return REQ_NV;
    else if (ins)
      return REQ_INSTR;
    else
      return REQ_NONE;
  endfunction
endpackage

// File: core/ffch_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to mclk
// Notes: First stage is read only by the second
`timescale 1ns/100ps
module ffch_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// File: core/ffch_top.sv
// What this block does
// R1: Signed mode refuses RAM-plus-NV frequency write, replies write mode error 01.
// R2: When occupancy nonzero and both writes asserted, RAM-only write goes first.
// R3: Signed mode reset: sign positive, frequency zero, NV value ignored; the code still loads NV in combined modes 1 or 3.
// R4: Combined panel/external modes 1 or 3 at reset load frequency from NV.
// R5: Frequency writes by instruction codes ED/EE change magnitude, keep sign.
// R6: Link data refreshed cyclically, 1.1 ms to 141 ms per station.
// R7: Occupancy 0 legacy, 1 single, 12/14/18 double/quad/octuple extension.
// R8: Legacy occupancy with all three requests asserted executes only one.
// R9: Legacy occupancy ignores upper 8 bits of command word two.
// R10: Master must match extension multiplicity; first-version masters cannot.
// R11: Occupancy change latched, applied only after the next drive reset.
// R12: Error reset acts only while a protective alarm is active.
// R13: Alarm history clear erases all eight stored alarms.
// R14: Three request bits from master, each with its own completion bit.
// R15: Signed frequency word is two's complement in 0.01 Hz steps; negative reverses.
// R16: Completion rises after processing, falls after master drops the request.
//
// Purpose: Remote-station command handler for frequency and instruction requests
// Assumes: Link side bits arrive from pins; register port on mclk
// Notes: One request is processed at a time
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module ffch_top
  import ffch_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic drive_reset_n,
  input wire logic freq_write_ram_req,
  input wire logic freq_write_nv_req,
  input wire logic instr_exec_req,
  input wire logic error_reset_req,
  input wire logic [15:0] command_word_one,
  input wire logic [15:0] command_word_two,
  input wire logic [15:0] command_word_three,
  input wire logic alarm_active,
  input wire logic alarm_event,
  input wire logic [7:0] alarm_code,
  input wire logic refresh_tick,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic freq_write_ram_done,
  output logic freq_write_nv_done,
  output logic instr_exec_done,
  output logic [7:0] reply_code,
  output logic [15:0] set_freq,
  output logic freq_sign_neg,
  output logic error_reset_pulse,
  output logic link_timeout,
  output logic [3:0] link_multiplicity,
  output logic irq
);
  logic [1:0] rst_sync;
  logic rst_n;
  logic pin_drst_n;
  logic pin_ram;
  logic pin_nv;
  logic pin_ins;
  logic pin_err;
  logic pin_alarm_act;
  logic pin_alarm_evt;
  logic pin_tick;
  logic drst_n_q;
  logic err_q;
  logic alarm_evt_q;
  logic tick_q;
  logic drive_reset_evt;
  logic freq_sign_select;
  logic [7:0] station_occupancy_setting;
  logic [7:0] occ_active;
  logic [3:0] operation_mode_select;
  logic [15:0] nv_freq;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  ffch_state_t state;
  ffch_req_t cur_req;
  ffch_req_t pick;
  logic [7:0] instr_code;
  logic ev_done;
  logic ev_err;
  logic hist_clear;
  logic [7:0] hist_data;
  logic [31:0] tick_cnt;
  logic [15:0] wdata;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  ffch_sync #(.W(8)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({drive_reset_n, freq_write_ram_req, freq_write_nv_req, instr_exec_req,
        error_reset_req, alarm_active, alarm_event, refresh_tick}),
    .q({pin_drst_n, pin_ram, pin_nv, pin_ins, pin_err, pin_alarm_act, pin_alarm_evt, pin_tick})
  );

  ffch_hist u_hist (
    .mclk(mclk),
    .rst_n(rst_n),
    .push(pin_alarm_evt && !alarm_evt_q),
    .code(alarm_code),
    .clear(hist_clear),
    .rd_idx(reg_addr[2:0]),
    .rd_data(hist_data)
  );

  // Edge detectors on synchronised pins
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drst_n_q <= 1'b1;
      err_q <= 1'b0;
      alarm_evt_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      drst_n_q <= pin_drst_n;
      err_q <= pin_err;
      alarm_evt_q <= pin_alarm_evt;
      tick_q <= pin_tick;
    end
  end
  // Drive reset acts on release so settings stay stable while held
  assign drive_reset_evt = pin_drst_n && !drst_n_q;

  // Error reset passes only with an active alarm
  assign error_reset_pulse = pin_err && !err_q && pin_alarm_act; // [R12]

  // Software configuration
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      freq_sign_select <= 1'b0;
      station_occupancy_setting <= CTRL_OCC_RESET;
      operation_mode_select <= 4'h0;
      nv_freq <= FREQ_RESET;
      irq_mask <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_CTRL)
      begin
        freq_sign_select <= reg_wdata[CTRL_SIGN_BIT];
        station_occupancy_setting <= reg_wdata[CTRL_OCC_LSB +: 8]; // [R11]
        operation_mode_select <= reg_wdata[CTRL_MODE_LSB +: 4];
      end
      if (reg_addr == ADDR_NV_FREQ)
        nv_freq <= reg_wdata[15:0];
      if (reg_addr == ADDR_IRQ_MASK)
        irq_mask <= reg_wdata[IRQ_W-1:0];
    end
    else if (state == ST_EXEC && cur_req == REQ_NV && !freq_sign_select)
      nv_freq <= command_word_one;
    else if (state == ST_EXEC && cur_req == REQ_INSTR && instr_code == SET_FREQ_NV_CODE && !freq_sign_select)
      nv_freq <= command_word_three;
  end

  // Occupancy takes effect only at a drive reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      occ_active <= CTRL_OCC_RESET;
    else if (drive_reset_evt)
      occ_active <= station_occupancy_setting; // [R11]
  end

  always_comb
  begin
    unique case (occ_active) // [R7]
      OCC_DOUBLE: link_multiplicity = 4'h2;
      OCC_QUAD: link_multiplicity = 4'h4;
      OCC_OCT: link_multiplicity = 4'h8;
      default: link_multiplicity = 4'h1;
    endcase
  end

  // Upper byte of the instruction word never reaches the decode
  assign instr_code = command_word_two[7:0]; // [R9]
  assign hist_clear = state == ST_EXEC && cur_req == REQ_INSTR && instr_code == HIST_CLEAR_CODE; // [R13]
  assign pick = ffch_pick(pin_ram, pin_nv, pin_ins); // [R2] [R8]

  // Request sequencer
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      cur_req <= REQ_NONE;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (pick != REQ_NONE)
          begin
            cur_req <= pick; // [R14]
            state <= ST_EXEC;
          end
        end
        ST_EXEC: state <= ST_DONE;
        ST_DONE: state <= ST_WAIT;
        ST_WAIT:
        begin
          // Hold until the served request drops
          if ((cur_req == REQ_RAM && !pin_ram) || (cur_req == REQ_NV && !pin_nv)
              || (cur_req == REQ_INSTR && !pin_ins))
          begin
            state <= ST_IDLE; // [R16]
            cur_req <= REQ_NONE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign wdata = freq_sign_select ? {1'b0, command_word_three[14:0]} : command_word_three;

  // Frequency, sign and reply
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      set_freq <= FREQ_RESET;
      freq_sign_neg <= 1'b0;
      reply_code <= REPLY_OK;
      ev_done <= 1'b0;
      ev_err <= 1'b0;
    end
    else
    begin
      ev_done <= state == ST_EXEC;
      ev_err <= 1'b0;
      if (drive_reset_evt)
      begin
        if (operation_mode_select == MODE_COMB_A || operation_mode_select == MODE_COMB_B)
          set_freq <= nv_freq; // [R4]
        else if (freq_sign_select)
          set_freq <= FREQ_RESET; // [R3]
        freq_sign_neg <= 1'b0; // [R3]
      end
      else if (state == ST_EXEC)
      begin
        reply_code <= REPLY_OK;
        unique case (cur_req)
          REQ_RAM:
          begin
            set_freq <= command_word_one;
            freq_sign_neg <= freq_sign_select && command_word_one[15]; // [R15]
          end
          REQ_NV:
          begin
            if (freq_sign_select)
            begin
              reply_code <= REPLY_WRITE_MODE_ERR; // [R1]
              ev_err <= 1'b1;
            end
            else
              set_freq <= command_word_one;
          end
          REQ_INSTR:
          begin
            if (instr_code == SET_FREQ_RAM_CODE || instr_code == SET_FREQ_NV_CODE)
              set_freq <= freq_sign_select ? {set_freq[15], wdata[14:0]} : wdata; // [R5]
            else if (instr_code != HIST_CLEAR_CODE)
            begin
              reply_code <= REPLY_BAD_CODE;
              ev_err <= 1'b1;
            end
          end
          default: reply_code <= REPLY_OK;
        endcase
      end
    end
  end

  assign freq_write_ram_done = (state == ST_DONE || state == ST_WAIT) && cur_req == REQ_RAM; // [R14]
  assign freq_write_nv_done = (state == ST_DONE || state == ST_WAIT) && cur_req == REQ_NV;
  assign instr_exec_done = (state == ST_DONE || state == ST_WAIT) && cur_req == REQ_INSTR;

  // Refresh watchdog; flags a gap longer than the slowest allowed refresh
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt <= 32'h0;
      link_timeout <= 1'b0;
    end
    else if (pin_tick && !tick_q)
    begin
      tick_cnt <= 32'h0;
      link_timeout <= 1'b0;
    end
    else if (tick_cnt >= 32'(REFRESH_MAX_CYC))
      link_timeout <= 1'b1; // [R6]
    else
      tick_cnt <= tick_cnt + 32'h1;
  end

  // Sticky interrupt status; set wins over write-one-clear
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat <= '0;
    else
      irq_stat <= (irq_stat & ~((reg_wr && reg_addr == ADDR_IRQ_STAT) ? reg_wdata[IRQ_W-1:0] : '0))
        | {error_reset_pulse, ev_err, ev_done};
  end
  assign irq = |(irq_stat & irq_mask);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      unique case (1'b1)
        reg_addr == ADDR_CTRL: reg_rdata <= {12'h0, operation_mode_select, station_occupancy_setting,
                                             7'h0, freq_sign_select};
        reg_addr == ADDR_STATUS: reg_rdata <= {8'h0, occ_active, reply_code, 3'h0, link_timeout, state};
        reg_addr == ADDR_IRQ_STAT: reg_rdata <= {29'h0, irq_stat};
        reg_addr == ADDR_IRQ_MASK: reg_rdata <= {29'h0, irq_mask};
        reg_addr == ADDR_FREQ: reg_rdata <= {15'h0, freq_sign_neg, set_freq};
        reg_addr == ADDR_NV_FREQ: reg_rdata <= {16'h0, nv_freq};
        reg_addr[3]: reg_rdata <= {24'h0, hist_data};
        default: reg_rdata <= 32'h0;
      endcase
    end
  end
endmodule

// File: tb/ffch_chk.sv
// Purpose: Port assertions for the command handler top
// Assumes: One clock domain, rstn active low
// Notes: Attached to every ffch_top by the bind at the foot
`timescale 1ns/100ps
module ffch_chk
  import ffch_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic drive_reset_n,
  input wire logic freq_write_ram_req,
  input wire logic instr_exec_req,
  input wire logic alarm_active,
  input wire logic reg_wr,
  input wire logic freq_write_ram_done,
  input wire logic freq_write_nv_done,
  input wire logic instr_exec_done,
  input wire logic [7:0] reply_code,
  input wire logic freq_sign_neg,
  input wire logic error_reset_pulse,
  input wire logic [3:0] link_multiplicity,
  input wire logic irq
);
  logic [3:0] since_drst;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Saturates so that a long quiet spell never looks like a fresh reset
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      since_drst <= 4'hF;
    else if (!drive_reset_n)
      since_drst <= 4'h0;
    else if (since_drst != 4'hF)
      since_drst <= since_drst + 4'h1;

  sequence s_ram_idle;
    !freq_write_ram_req [*5];
  endsequence

  sequence s_one_pulse;
    error_reset_pulse ##1 !error_reset_pulse;
  endsequence

  ram_done_cause_a: assert property
    ($rose(freq_write_ram_done) |-> freq_write_ram_req && $past(freq_write_ram_req, 3))
    else $error("ram completion without request");
  ins_done_cause_a: assert property
    ($rose(instr_exec_done) |-> instr_exec_req && $past(instr_exec_req, 3))
    else $error("instruction completion without request");
  ram_done_drop_a: assert property (s_ram_idle |-> !freq_write_ram_done)
    else $error("ram completion outlives request");
  one_done_a: assert property ($onehot0({freq_write_ram_done, freq_write_nv_done, instr_exec_done}))
    else $error("two completions at once");
  ram_first_a: assert property ($rose(freq_write_nv_done) |-> !freq_write_ram_req)
    else $error("nv write served before ram write");
  mode_err_a: assert property
    ($changed(reply_code) && reply_code == REPLY_WRITE_MODE_ERR |-> freq_write_nv_done)
    else $error("write mode error outside nv write");
  sign_kept_a: assert property ($rose(instr_exec_done) |-> $stable(freq_sign_neg))
    else $error("instruction write changed sign");
  err_reset_a: assert property
    ($rose(error_reset_pulse) |-> ($past(alarm_active, 2) || $past(alarm_active, 3)) ##0 s_one_pulse)
    else $error("error reset pulse without alarm");
  occ_apply_a: assert property ($changed(link_multiplicity) |-> since_drst < 4'h8)
    else $error("occupancy applied without drive reset");
  irq_fall_a: assert property ($fell(irq) |-> $past(reg_wr) || since_drst < 4'h8)
    else $error("interrupt dropped without register write");
endmodule

bind ffch_top ffch_chk u_chk (.*);

// File: tb/ffch_master.sv
// Purpose: Network master station model for the command handler
// Assumes: Signals change by non-blocking assignment just after mclk rises
// Notes: Link words turn to inverted junk once a request is dropped
`timescale 1ns/100ps
module ffch_master
  import ffch_pkg::*;
(
  input wire logic mclk,
  input wire logic [2:0] done_bits,
  input wire logic [7:0] reply_code,
  output logic freq_write_ram_req,
  output logic freq_write_nv_req,
  output logic instr_exec_req,
  output logic [15:0] command_word_one,
  output logic [15:0] command_word_two,
  output logic [15:0] command_word_three,
  output logic refresh_tick
);
  initial
  begin
    {freq_write_ram_req, freq_write_nv_req, instr_exec_req, refresh_tick} = 4'h0;
    {command_word_one, command_word_two, command_word_three} = 48'h0;
  end

  // Shortest legal interval, so the run stays short
  always
  begin
    repeat (REFRESH_MIN_CYC) @(posedge mclk);
    refresh_tick <= 1'b1;
    @(posedge mclk);
    refresh_tick <= 1'b0;
  end

  // Holds words and request until completion, then waits for it to clear
  task automatic send(input logic [2:0] req, input logic [15:0] w1, input logic [15:0] w2,
                      input logic [15:0] w3, output logic [2:0] got, output logic [7:0] rep);
    got = 3'b000;
    rep = 8'h00;
    @(posedge mclk);
    {freq_write_ram_req, freq_write_nv_req, instr_exec_req} <= req;
    {command_word_one, command_word_two, command_word_three} <= {w1, w2, w3};
    for (int i = 0; i < 30 && got == 3'b000; i++)
    begin
      @(posedge mclk);
      #1;
      got = done_bits;
      rep = reply_code;
    end
    @(posedge mclk);
    {freq_write_ram_req, freq_write_nv_req, instr_exec_req} <= 3'b000;
    {command_word_one, command_word_two, command_word_three} <= ~{w1, w2, w3};
    for (int i = 0; i < 30 && done_bits != 3'b000; i++)
      @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask
endmodule

// File: tb/ffch_top_tb_top.sv
// Purpose: Self-checking bench for the command handler
// Assumes: 40 MHz mclk, master model drives the link side
// Notes: Occupancy rows first, then hand-written cases
`timescale 1ns/100ps
module ffch_top_tb_top
  import ffch_pkg::*;
;
  typedef struct {logic [7:0] occ; logic [3:0] mult;} ffch_row_t;
  ffch_row_t rows [5] = '{'{OCC_LEGACY, 4'h1}, '{OCC_DOUBLE, 4'h2}, '{OCC_QUAD, 4'h4},
                          '{OCC_OCT, 4'h8}, '{OCC_SINGLE, 4'h1}};
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic drive_reset_n = 1'b1;
  logic error_reset_req = 1'b0;
  logic alarm_active = 1'b0;
  logic alarm_event = 1'b0;
  logic [7:0] alarm_code = 8'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic freq_write_ram_req, freq_write_nv_req, instr_exec_req, refresh_tick;
  logic [15:0] command_word_one, command_word_two, command_word_three, set_freq;
  logic freq_write_ram_done, freq_write_nv_done, instr_exec_done, freq_sign_neg;
  logic error_reset_pulse, link_timeout, irq, irq0;
  logic [31:0] reg_rdata, q;
  logic [7:0] reply_code, rep;
  logic [3:0] link_multiplicity, prev;
  logic [2:0] done_bits, got;
  int n_fail = 0;
  int n_tests = 0;
  int n_pulse = 0;

  assign done_bits = {freq_write_ram_done, freq_write_nv_done, instr_exec_done};
  always #12.5 mclk = ~mclk;
  always @(posedge mclk)
    if (error_reset_pulse === 1'b1)
      n_pulse++;

  ffch_top u_dut (.*);
  ffch_master u_master (.*);

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want)
    begin
      n_fail++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Occupancy and start value only move on this release
  task automatic drst();
    @(posedge mclk);
    drive_reset_n <= 1'b0;
    repeat (4) @(posedge mclk);
    drive_reset_n <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
  endtask

  task automatic err_req();
    @(posedge mclk);
    error_reset_req <= 1'b1;
    repeat (6) @(posedge mclk);
    error_reset_req <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #500000;
    n_fail++;
    give_verdict();
  end

  initial
  begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    check({set_freq, freq_sign_neg, irq, link_multiplicity}, 22'h1);
    rd(ADDR_CTRL, q);
    check(q, 32'h0);
    prev = 4'h1;
    // Master station is taken to match each multiplicity in turn
    foreach (rows[i])
    begin
      wr(ADDR_CTRL, {16'h0, rows[i].occ, 8'h00});
      repeat (4) @(posedge mclk);
      check(link_multiplicity, prev);
      drst();
      check(link_multiplicity, rows[i].mult);
      prev = rows[i].mult;
    end
    u_master.send(3'b100, 16'h04D2, 16'h0, 16'h0, got, rep);
    check({got, rep, set_freq}, {3'b100, REPLY_OK, 16'h04D2});
    u_master.send(3'b110, 16'h0100, 16'h0, 16'h0, got, rep);
    check({got, set_freq}, {3'b100, 16'h0100});
    wr(ADDR_IRQ_MASK, 32'h0);
    rd(ADDR_IRQ_STAT, q);
    check(q[IRQ_DONE], 1'b1);
    irq0 = irq;
    wr(ADDR_IRQ_MASK, 32'hF);
    check(irq0 ^ irq, 1'b1);
    wr(ADDR_IRQ_STAT, 32'hF);
    wr(ADDR_IRQ_MASK, 32'h0);
    rd(ADDR_IRQ_STAT, q);
    check({q[IRQ_W-1:0], irq}, 4'h0);
    rd(4'h6, q);
    check(q, 32'h0);
    wr(ADDR_CTRL, 32'h0);
    drst();
    u_master.send(3'b111, 16'h0200, 16'hA5ED, 16'h0300, got, rep);
    check(got, 3'b100);
    u_master.send(3'b001, 16'h0, 16'hA5ED, 16'h0300, got, rep);
    check({got, rep, set_freq}, {3'b001, REPLY_OK, 16'h0300});
    wr(ADDR_NV_FREQ, 32'h1111);
    wr(ADDR_CTRL, 32'h1);
    u_master.send(3'b010, 16'h0500, 16'h0, 16'h0, got, rep);
    check({got, rep}, {3'b010, REPLY_WRITE_MODE_ERR});
    u_master.send(3'b100, 16'hFF38, 16'h0, 16'h0, got, rep);
    check(freq_sign_neg, 1'b1);
    u_master.send(3'b001, 16'h0, {8'h00, SET_FREQ_RAM_CODE}, 16'h0064, got, rep);
    check({got, freq_sign_neg}, 4'h3);
    u_master.send(3'b001, 16'h0, {8'h00, SET_FREQ_NV_CODE}, 16'h0065, got, rep);
    check({got, rep, freq_sign_neg}, {3'b001, REPLY_OK, 1'b1});
    drst();
    check({freq_sign_neg, set_freq}, 17'h0);
    for (int k = 1; k < 4; k += 2)
    begin
      wr(ADDR_NV_FREQ, 32'h1111 * k);
      wr(ADDR_CTRL, 32'h1 | (k << CTRL_MODE_LSB));
      drst();
      check(set_freq, 32'h1111 * k);
    end
    err_req();
    check(n_pulse, 0);
    @(posedge mclk);
    alarm_active <= 1'b1;
    err_req();
    alarm_active <= 1'b0;
    check(n_pulse, 1);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk);
      {alarm_code, alarm_event} <= {8'h5A + 8'(k), 1'b1};
      repeat (4) @(posedge mclk);
      alarm_event <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    rd(ADDR_HIST_BASE, q);
    check(q[7:0], 8'h5B);
    u_master.send(3'b001, 16'h0, {8'h00, HIST_CLEAR_CODE}, 16'h0, got, rep);
    rd(ADDR_HIST_BASE, q);
    check(q, 32'h0);
    rd(ADDR_HIST_BASE + 4'h1, q);
    check(q, 32'h0);
    check(link_timeout, 1'b0);
    give_verdict();
  end
endmodule
